// ==== src/lgbm_pkg.sv ====
package lgbm_pkg;
    // ==========================================================
    // register subaddresses
    localparam logic [5:0] GAMMA_BASE_ADDR  = 6'h26;
    localparam logic [5:0] BRIGHT_ADDR      = 6'h34;
    localparam logic [5:0] CLKCTL_ADDR      = 6'h35;
    // ==========================================================
    // curve layout: seven knots per curve, curve b after curve a
    localparam int         KNOTS            = 7;
    localparam int         CURVE_REGS       = 2 * KNOTS;
    // fixed curve points
    localparam logic [7:0] FIX_LOW          = 8'h10;
    localparam logic [7:0] FIX_HIGH         = 8'hF0;
    localparam logic [7:0] FIRST_KNOT       = 8'h20;
    localparam int         SEG_SHIFT        = 5;
    // ==========================================================
    // clock output control fields and reset value
    localparam int         AUX_CLOCK_OUTPUT_PIN_EN_POS    = 1;
    localparam logic [7:0] CLKCTL_RESET     = 8'h70;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;
    // ==========================================================
    // brightness measurement sizes
    localparam int         ACC_W            = 26;
    localparam int         CNT_W            = 18;
    localparam int         QUOT_W           = 8;
    // divider state
    typedef enum logic [0:0] {
        LGBM_DIV_IDLE = 1'b0,
        LGBM_DIV_RUN  = 1'b1
    } lgbm_div_t;
endpackage

// ==== src/lgbm_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module lgbm_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         clk_in,     // pixel clock
    input  wire logic         rst_in,     // async reset, high
    input  wire logic         s_valid_in, // write side valid
    output logic              s_ready_out,// write side ready
    input  wire logic [W-1:0] s_data_in,  // write data
    output logic              m_valid_out,// read side valid
    input  wire logic         m_ready_in, // read side ready
    output logic      [W-1:0] m_data_out  // read data
);
    localparam int AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D || W < 1) begin
            $error("lgbm_fifo: depth must be a power of two >= 2");
        end
    end
    // ==========================================================
    // storage with one extra pointer bit to tell full from empty
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire          empty = (wp_q == rp_q);
    wire          push  = s_valid_in && !full;
    wire          pop   = m_valid_out && m_ready_in;

    assign s_ready_out = !full;
    assign m_valid_out = !empty;
    assign m_data_out  = mem[rp_q[AW-1:0]];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= s_data_in;
        end
    end
endmodule
`default_nettype wire

// ==== src/lgbm_top.sv ====
// Behaviour
// - gamma touches luma only; chroma passes unchanged.
// - two programmable curves; the select input picks exactly one.
// - seven programmable knots at inputs 32,64,...,224 on a 256 scale.
// - between neighbouring knots output is linearly interpolated.
// - points 0, 16, 240, 255 are fixed; writes cannot move them.
// - read-only 8-bit average brightness register at subaddress 0x34.
// - only active-video luma samples are accumulated.
// - brightness register refreshes once per field on vsync falling edge.
// - clock-out enable bit drives the 54 MHz clock onto the pin.
// - enable only acts with pll on and oversampling on.
`timescale 1ns/1ps
`default_nettype none
module lgbm_top #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic       clk_in,         // pixel clock, 10 MHz
    input  wire logic       rst_in,         // async reset, high
    input  wire logic [5:0] reg_addr_in,    // register subaddress
    input  wire logic       reg_wr_in,      // write strobe
    input  wire logic [7:0] reg_wdata_in,   // write data
    input  wire logic       reg_rd_in,      // read strobe
    output logic      [7:0] reg_rdata_out,  // read data, valid next cycle
    input  wire logic       pix_valid_in,   // sample valid
    output logic            pix_ready_out,  // fifo has room
    input  wire logic [7:0] luma_in,        // luma sample
    input  wire logic [7:0] chroma_in,      // chroma sample
    input  wire logic       active_in,      // active video area
    input  wire logic       vsync_n_in,     // vertical sync, low active
    input  wire logic       curve_sel_in,   // 0 curve a, 1 curve b
    input  wire logic       pll_disable_in, // pll disable mode bit
    input  wire logic       oversample_in,  // 4x oversampling mode bit
    input  wire logic       pll_clk_in,     // 54 MHz pll clock
    output logic            pix_valid_out,  // output sample valid
    input  wire logic       pix_ready_in,   // downstream ready
    output logic      [7:0] luma_out,       // corrected luma
    output logic      [7:0] chroma_out,     // chroma, untouched
    output logic            aux_clock_out   // gated pll clock pin
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("lgbm_top: fifo depth too small");
        end
    end
    // ==========================================================
    // input fifo
    logic        f_valid;
    logic [15:0] f_data;
    logic        stage_load;
    wire         stage_free = !pix_valid_out || pix_ready_in;
    wire         take       = pix_valid_in && pix_ready_out;
    assign stage_load = f_valid && stage_free;

    lgbm_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .s_valid_in  (pix_valid_in),
        .s_ready_out (pix_ready_out),
        .s_data_in   ({luma_in, chroma_in}),
        .m_valid_out (f_valid),
        .m_ready_in  (stage_free),
        .m_data_out  (f_data)
    );
    wire [7:0] f_luma   = f_data[15:8];
    wire [7:0] f_chroma = f_data[7:0];
    // ==========================================================
    // curve registers and knot selection
    logic [7:0] gamma_q [lgbm_pkg::CURVE_REGS];
    logic [7:0] bp [lgbm_pkg::KNOTS];
    for (genvar g = 0; g < lgbm_pkg::KNOTS; g++) begin : g_bp
        assign bp[g] = curve_sel_in ? gamma_q[g + lgbm_pkg::KNOTS] : gamma_q[g];
    end

    function automatic logic [7:0] interp(input logic [7:0] ya, input logic [7:0] yb,
                                          input logic [4:0] off);
        logic signed [9:0]  diff;
        logic signed [15:0] prod;
        diff   = $signed({2'b00, yb}) - $signed({2'b00, ya});
        prod   = 16'(diff * $signed({1'b0, off}));
        interp = 8'($signed({2'b00, ya}) + 10'(prod >>> lgbm_pkg::SEG_SHIFT));
    endfunction

    // ==========================================================
    // gamma segment decode
    wire [2:0] seg      = f_luma[7:5];
    wire       in_fixed = (f_luma < lgbm_pkg::FIX_LOW) || (f_luma >= lgbm_pkg::FIX_HIGH);
    wire       in_first = (f_luma < lgbm_pkg::FIRST_KNOT);
    wire       in_last  = (seg == 3'h7);
    wire [2:0] ka       = (seg == 3'h0) ? 3'h0 : 3'(seg - 3'h1);
    wire [7:0] ya       = in_first ? lgbm_pkg::FIX_LOW : bp[ka];
    wire [7:0] yb       = in_last ? lgbm_pkg::FIX_HIGH : (in_first ? bp[0] : bp[seg]);
    // half-width end segments reuse the 32-wide slope by doubling the offset
    wire [4:0] off      = (in_first || in_last) ? {f_luma[3:0], 1'b0} : f_luma[4:0];
    wire [7:0] gam      = in_fixed ? f_luma : interp(ya, yb, off);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pix_valid_out <= 1'b0;
            luma_out      <= 8'h00;
            chroma_out    <= 8'h00;
        end else begin
            if (stage_free) begin
                pix_valid_out <= f_valid;
            end
            if (stage_load) begin
                luma_out   <= gam;
                chroma_out <= f_chroma;
            end
        end
    end
    // ==========================================================
    // register port
    logic [7:0] clkctl_q;
    logic [7:0] bright_q;
    wire  [5:0] gidx     = 6'(reg_addr_in - lgbm_pkg::GAMMA_BASE_ADDR);
    wire        gam_hit  = (reg_addr_in >= lgbm_pkg::GAMMA_BASE_ADDR) &&
                           (gidx < 6'(lgbm_pkg::CURVE_REGS));
    wire  [7:0] rd_mux   = gam_hit ? gamma_q[gidx[3:0]] :
                           (reg_addr_in == lgbm_pkg::BRIGHT_ADDR) ? bright_q :
                           (reg_addr_in == lgbm_pkg::CLKCTL_ADDR) ? clkctl_q :
                           lgbm_pkg::UNMAPPED_READ;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            clkctl_q      <= lgbm_pkg::CLKCTL_RESET;
            for (int i = 0; i < lgbm_pkg::CURVE_REGS; i++) begin
                gamma_q[i] <= 8'(32 * ((i % lgbm_pkg::KNOTS) + 1));
            end
        end else begin
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
            // fixed points have no storage, so no write can reach them
            if (reg_wr_in && gam_hit) begin
                gamma_q[gidx[3:0]] <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == lgbm_pkg::CLKCTL_ADDR) begin
                clkctl_q <= reg_wdata_in;
            end
        end
    end
    // ==========================================================
    // clock output gating
    logic clk_en_q;
    wire  clk_en_d = clkctl_q[lgbm_pkg::AUX_CLOCK_OUTPUT_PIN_EN_POS] && !pll_disable_in && oversample_in;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_en_q <= 1'b0;
        end else begin
            clk_en_q <= clk_en_d;
        end
    end
    // a plain and-gate glitches when the enable moves; a cell latch belongs here
    assign aux_clock_out = pll_clk_in && clk_en_q;
    // ==========================================================
    // brightness measurement
    logic                      vs_q;
    logic [lgbm_pkg::ACC_W-1:0] acc_q;
    logic [lgbm_pkg::CNT_W-1:0] cnt_q;
    wire  vs_fall = vs_q && !vsync_n_in;
    wire  sample  = take && active_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vs_q  <= 1'b1;
            acc_q <= '0;
            cnt_q <= '0;
        end else begin
            vs_q <= vsync_n_in;
            // a sample in the edge cycle opens the new field
            if (vs_fall) begin
                acc_q <= sample ? lgbm_pkg::ACC_W'(luma_in) : '0;
                cnt_q <= sample ? lgbm_pkg::CNT_W'(1) : '0;
            end else if (sample) begin
                acc_q <= acc_q + lgbm_pkg::ACC_W'(luma_in);
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
    // ==========================================================
    // restoring divider: mean never exceeds 255, so eight steps suffice
    lgbm_pkg::lgbm_div_t        div_q;
    logic [lgbm_pkg::ACC_W-1:0] rem_q;
    logic [lgbm_pkg::CNT_W-1:0] dvs_q;
    logic [lgbm_pkg::QUOT_W-1:0] quo_q;
    logic [2:0]                  step_q;
    wire  [lgbm_pkg::ACC_W+7:0]  trial  = 34'(dvs_q) << step_q;
    wire                         fits   = 34'(rem_q) >= trial;
    wire                         div_done = (div_q == lgbm_pkg::LGBM_DIV_RUN) && (step_q == 3'h0);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q    <= lgbm_pkg::LGBM_DIV_IDLE;
            rem_q    <= '0;
            dvs_q    <= '0;
            quo_q    <= '0;
            step_q   <= 3'h0;
            bright_q <= 8'h00;
        end else begin
            unique case (div_q)
                lgbm_pkg::LGBM_DIV_IDLE: begin
                    if (vs_fall) begin
                        rem_q  <= acc_q;
                        dvs_q  <= cnt_q;
                        quo_q  <= '0;
                        step_q <= 3'h7;
                        div_q  <= lgbm_pkg::LGBM_DIV_RUN;
                    end
                end
                lgbm_pkg::LGBM_DIV_RUN: begin
                    if (fits && dvs_q != '0) begin
                        rem_q <= lgbm_pkg::ACC_W'(34'(rem_q) - trial);
                    end
                    quo_q[step_q] <= fits && dvs_q != '0;
                    step_q        <= 3'(step_q - 3'h1);
                    if (div_done) begin
                        bright_q <= {quo_q[7:1], fits && dvs_q != '0};
                        div_q    <= lgbm_pkg::LGBM_DIV_IDLE;
                    end
                end
            endcase
        end
    end
    // ==========================================================
    // assertions
    a_chroma_pass: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load |=> chroma_out == $past(f_chroma))
        else $error("chroma altered");
    a_fixed_low: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load && f_luma < 8'h10 |=> luma_out == $past(f_luma))
        else $error("low fixed point moved");
    a_fixed_high: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load && f_luma >= 8'hF0 |=> luma_out == $past(f_luma))
        else $error("high fixed point moved");
    a_knot_sel_b: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load && f_luma == 8'h80 && curve_sel_in |=> luma_out == $past(gamma_q[10]))
        else $error("curve b knot not used");
    a_knot_hit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load && f_luma == 8'h20 && !curve_sel_in |=> luma_out == $past(gamma_q[0]))
        else $error("curve a first knot wrong");
    a_interp_mid: assert property (@(posedge clk_in) disable iff (rst_in)
        stage_load && f_luma == 8'h30 |=> luma_out == 8'(($past(9'(bp[0])) + $past(9'(bp[1]))) >> 1))
        else $error("midpoint interpolation wrong");
    a_blank_skip: assert property (@(posedge clk_in) disable iff (rst_in)
        take && !active_in && !vs_fall |=> $stable(acc_q) && $stable(cnt_q))
        else $error("blanking sample accumulated");
    a_acc_restart: assert property (@(posedge clk_in) disable iff (rst_in)
        vs_fall && !sample |=> acc_q == '0 && cnt_q == '0)
        else $error("accumulator not cleared at field");
    a_bright_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !div_done |=> $stable(bright_q))
        else $error("brightness changed mid field");
    a_bright_time: assert property (@(posedge clk_in) disable iff (rst_in)
        vs_fall && div_q == lgbm_pkg::LGBM_DIV_IDLE |-> ##8 div_done)
        else $error("brightness not refreshed in 9 cycles");
    a_bright_read: assert property (@(posedge clk_in) disable iff (rst_in)
        reg_rd_in && reg_addr_in == 6'h34 |=> reg_rdata_out == $past(bright_q))
        else $error("brightness readback wrong");
    a_aux_clock_output_pin_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        pll_disable_in || !oversample_in |=> !clk_en_q)
        else $error("clock out enabled without pll");
    c_field_done: cover property (@(posedge clk_in) disable iff (rst_in) div_done && dvs_q != '0);
    c_fifo_full:  cover property (@(posedge clk_in) disable iff (rst_in) pix_valid_in && !pix_ready_out);
    c_curve_b:    cover property (@(posedge clk_in) disable iff (rst_in) stage_load && curve_sel_in);
    c_clk_on:     cover property (@(posedge clk_in) disable iff (rst_in) clk_en_q);
endmodule
`default_nettype wire

// ==== testbench/lgbm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lgbm_host_model (
    input  wire logic       clk_in,    // pixel clock
    input  wire logic [7:0] rdata_in,  // read data from device
    output logic      [5:0] addr_out,  // register subaddress
    output logic            wr_out,    // write strobe
    output logic      [7:0] wdata_out, // write data
    output logic            rd_out     // read strobe
);
    logic [7:0] kn [2][7];

    initial begin
        addr_out = 6'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
    end

    // ==========================================================
    // register cycles
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        // released data must not look like a held value
        wdata_out = ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask

    // ==========================================================
    // curve and clock control programming
    task automatic load_curve(input int c, input real g);
        real y;
        for (int i = 0; i < 7; i++) begin
            y = $pow((32.0 * (i + 1) - 16.0) / 224.0, g) * 224.0 + 16.0;
            kn[c][i] = (y < 16.0) ? 8'h10 : (y > 240.0) ? 8'hF0 : 8'(int'(y));
            wr(6'(lgbm_pkg::GAMMA_BASE_ADDR + 6'(c * 7 + i)), kn[c][i]);
        end
    endtask

    task automatic set_clk_out(input logic en);
        wr(lgbm_pkg::CLKCTL_ADDR, 8'h70 | {6'h00, en, 1'b0});
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_luma_gamma_brightness_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_luma_gamma_brightness_monitor;
    localparam int DEPTH = 8;
    logic       clk_in = 1'b0, rst_in = 1'b1, pll_clk = 1'b0;
    logic [5:0] reg_addr;
    logic       reg_wr, reg_rd, pix_ready_out, pix_valid_out, aux_clock_out;
    logic [7:0] reg_wdata, reg_rdata, luma_out, chroma_out, rv;
    logic       pix_valid_in = 1'b0, active_in = 1'b0, vsync_n_in = 1'b1, curve_sel_in = 1'b0;
    logic       pll_disable_in = 1'b0, oversample_in = 1'b1, pix_ready_in = 1'b1;
    logic [7:0] luma_in = 8'h00, chroma_in = 8'h00;
    logic [15:0] exp_q [$];
    int         error_cnt = 0, samples_checked = 0, n;
    logic [7:0] lv [15] = '{8'h00, 8'h0F, 8'h10, 8'h18, 8'h1F, 8'h20, 8'h30, 8'h64, 8'h80, 8'hDF, 8'hE0, 8'hE8,
                            8'hEF, 8'hF0, 8'hFF};

    always #50 clk_in = ~clk_in;
    // free running pll clock near 54 MHz
    always #9.259 pll_clk = ~pll_clk;

    lgbm_host_model host (.clk_in(clk_in), .rdata_in(reg_rdata), .addr_out(reg_addr), .wr_out(reg_wr),
                          .wdata_out(reg_wdata), .rd_out(reg_rd));

    lgbm_top #(.FIFO_DEPTH(DEPTH)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .pix_valid_in(pix_valid_in), .pix_ready_out(pix_ready_out), .luma_in(luma_in),
        .chroma_in(chroma_in), .active_in(active_in), .vsync_n_in(vsync_n_in),
        .curve_sel_in(curve_sel_in), .pll_disable_in(pll_disable_in), .oversample_in(oversample_in),
        .pll_clk_in(pll_clk), .pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in),
        .luma_out(luma_out), .chroma_out(chroma_out), .aux_clock_out(aux_clock_out));

    // ==========================================================
    // compare and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // stream side
    function automatic logic [7:0] gam(input int c, input int x);
        int ya, yb, off;
        if (x < 16 || x >= 240) return 8'(x);
        ya = (x < 32) ? 16 : host.kn[c][x / 32 - 1];
        yb = (x >= 224) ? 240 : host.kn[c][x / 32];
        off = (x < 32) ? (x - 16) * 2 : (x >= 224) ? (x - 224) * 2 : x % 32;
        // floor, not truncation, so falling user curves match as well
        return 8'(ya + (((yb - ya) * off) >>> 5));
    endfunction

    // valid stays up so back-to-back sends never reassign it in one step
    task automatic send(input logic [7:0] y, input logic [7:0] c, input logic act);
        pix_valid_in = 1'b1;
        luma_in = y;
        chroma_in = c;
        active_in = act;
        while (pix_ready_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        #1;
        exp_q.push_back({gam(int'(curve_sel_in), int'(y)), c});
    endtask

    task automatic idle_drain();
        pix_valid_in = 1'b0;
        luma_in = ~luma_in;
        n = 0;
        while (exp_q.size() > 0 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check(16'(exp_q.size()), 16'h0000);
    endtask

    always @(posedge clk_in) begin
        if (!rst_in && pix_valid_out === 1'b1 && pix_ready_in === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("BAD t=%0t seen=%h exp=none", $time, {luma_out, chroma_out});
            end else begin
                check({luma_out, chroma_out}, exp_q.pop_front());
            end
        end
    end

    task automatic field_end();
        vsync_n_in = 1'b0;
        @(posedge clk_in);
        #1;
        vsync_n_in = 1'b1;
        repeat (12) @(posedge clk_in);
        #1;
    endtask

    task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        check({8'h00, rv}, {8'h00, exp});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        #(100 * 20000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        rd_check(lgbm_pkg::CLKCTL_ADDR, 8'h70);
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h00);
        rd_check(6'h26, 8'h20);
        rd_check(6'h33, 8'hE0);
        host.wr(6'h3F, 8'hA5);
        rd_check(6'h3F, 8'h00);
        host.wr(lgbm_pkg::BRIGHT_ADDR, 8'hFF);
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h00);
        // clock pin: enable bit against both mode bits
        for (int k = 0; k < 5; k++) begin
            host.set_clk_out(k != 4);
            pll_disable_in = k[0];
            oversample_in = ~k[1];
            repeat (3) @(posedge clk_in);
            for (int j = 0; j < 6; j++) begin
                #7;
                check({15'h0000, aux_clock_out}, {15'h0000, pll_clk & (k == 0)});
            end
        end
        rd_check(lgbm_pkg::CLKCTL_ADDR, 8'h70);
        // two distinct curves over six of the eight segments and every fixed point
        host.load_curve(0, 0.5);
        host.load_curve(1, 2.0);
        for (int c = 0; c < 2; c++) begin
            curve_sel_in = c[0];
            foreach (lv[i]) send(lv[i], 8'(i * 17), 1'b0);
            idle_drain();
        end
        // stall the far side: fifo plus output stage, then refusal
        pix_ready_in = 1'b0;
        n = 0;
        while (pix_ready_out === 1'b1 && n < 20) begin
            send(8'(40 + n * 9), 8'(n), 1'b0);
            n++;
        end
        check(16'(n), 16'(DEPTH + 1));
        repeat (3) @(posedge clk_in);
        #1;
        check({15'h0000, pix_ready_out}, 16'h0000);
        pix_ready_in = 1'b1;
        idle_drain();
        // brightness: active samples only, one update per field
        field_end();
        foreach (lv[i]) send(lv[i], 8'h80, (i % 3) == 0);
        send(8'hFF, 8'h80, 1'b0);
        idle_drain();
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h00);
        field_end();
        // active samples 0, 24, 48, 223, 239: floor(534 / 5)
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h6A);
        send(8'h00, 8'h80, 1'b1);
        send(8'h01, 8'h80, 1'b1);
        send(8'hF0, 8'h80, 1'b0);
        idle_drain();
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h6A);
        field_end();
        rd_check(lgbm_pkg::BRIGHT_ADDR, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
